/* pkg/spicl_regs.svh */
// Behaviour
// - only one slave selected at once
// - unwritten slave echoes last received byte
// - wait mode runs normally, events wake
// - halt freezes control, blocks writes; done, overrun flags, data still update, readable
// - slave transfer-done wakes from halt
// - several bytes in halt set overrun
// - halt wake only if select low
// - extra transfer restores normal; leaving slave
// - one shared interrupt, enable and mask
// - bit7 enables requests on flags
// - port enable cleared by reset, fault
// - bit5 bypasses divide-by-two except at rate 3 (falls to 8), master only
// - master select cleared on mode fault
// - bit3 sets clock idle level
// - bit2 selects first capture edge
// - divider selects bit clock rate
// - upper control bits reset to zero
// - control/status resets zero, field layout
// - soft management picks soft select level
// - select low in master sets fault
`ifndef SPICL_REGS_SVH
`define SPICL_REGS_SVH
`define SPICL_OFF_DATA    12'h000
`define SPICL_OFF_CTRL    12'h004
`define SPICL_OFF_CSR     12'h008
`define SPICL_OFF_PWR     12'h00C
`define SPICL_B_IRQEN     7
`define SPICL_B_PORTEN    6
`define SPICL_B_BYPASS    5
`define SPICL_B_MASTER    4
`define SPICL_B_IDLE      3
`define SPICL_B_PHASE     2
`define SPICL_B_DONE      7
`define SPICL_B_WRITE_COLLISION_FLAG      6
`define SPICL_B_OVR       5
`define SPICL_B_MODE_FAULT_FLAG      4
`define SPICL_B_OUTDIS    2
`define SPICL_B_SSM       1
`define SPICL_B_SSI       0
`define SPICL_CTRL_RST    8'h00
`define SPICL_CSR_RST     8'h00
`endif

/* pkg/spicl_pkg.sv */
package spicl_pkg;
    typedef enum logic [1:0] {SPICL_RUN, SPICL_HALT, SPICL_RECOVER}
        spicl_pwr_t;
endpackage

/* rtl/spi_control_lowpower_irq.sv */
`timescale 1ns/1ns
`include "spicl_regs.svh"
module spi_control_lowpower_irq (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        haltReq,
    input  wire logic        cpuIrqMask,
    output logic             irqReq,
    output logic             wakeFromWait,
    output logic             wakeFromHalt,
    input  wire logic        sckIn,
    output logic             sckOut,
    output logic             sckOe,
    input  wire logic        mosiIn,
    output logic             mosiOut,
    output logic             mosiOe,
    input  wire logic        misoIn,
    output logic             misoOut,
    output logic             misoOe,
    input  wire logic        selectPinN,
    output logic             pinsAltFunc
);
    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic       acc;
    logic       wr;
    logic       rd;
    logic [7:0] ctrl_q;
    logic [7:0] csr_q;
    logic [7:0] rxBuf_q;
    logic [7:0] shift_q;
    spicl_pkg::spicl_pwr_t pwr_q;
    logic       halted;
    logic       csrSeen_q;
    logic       modfSeen_q;
    logic       busy_q;
    logic       master;
    logic       selInN;
    logic       modeFault;
    logic       doneEv;
    logic       wrData;
    logic       wrDataOk;

    assign acc    = psel & penable;
    assign wr     = acc & pwrite;
    assign rd     = acc & ~pwrite;
    assign halted = (pwr_q == spicl_pkg::SPICL_HALT);
    assign master = ctrl_q[`SPICL_B_MASTER];
    assign selInN = csr_q[`SPICL_B_SSM] ? csr_q[`SPICL_B_SSI]
                                        : selectPinN;
    assign modeFault = master & ~selInN & ctrl_q[`SPICL_B_PORTEN];
    assign wrData   = wr & (paddr == `SPICL_OFF_DATA) & ~halted;
    // writes blocked while done flag pending until status accessed
    assign wrDataOk = wrData & ~busy_q
                      & ~(csr_q[`SPICL_B_DONE] & ~csrSeen_q);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & (paddr > `SPICL_OFF_PWR);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            case (paddr)
                `SPICL_OFF_DATA: prdata <= {24'h000000, rxBuf_q};
                `SPICL_OFF_CTRL: prdata <= {24'h000000, ctrl_q};
                `SPICL_OFF_CSR:  prdata <= {24'h000000, csr_q};
                `SPICL_OFF_PWR:  prdata <= {30'h0, pwr_q};
                default:         prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // low power state
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pwr_q <= spicl_pkg::SPICL_RUN;
        end else begin
            case (pwr_q)
                spicl_pkg::SPICL_RUN:
                    if (haltReq)
                        pwr_q <= spicl_pkg::SPICL_HALT;
                spicl_pkg::SPICL_HALT:
                    if (wakeFromHalt)
                        pwr_q <= spicl_pkg::SPICL_RECOVER;
                spicl_pkg::SPICL_RECOVER:
                    if (!master && doneEv)
                        pwr_q <= spicl_pkg::SPICL_RUN;
                    else if (master)
                        pwr_q <= spicl_pkg::SPICL_RUN;
                default: pwr_q <= spicl_pkg::SPICL_RUN;
            endcase
        end
    end

    // halt arm captured at entry: select must be low then
    logic haltArm_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            haltArm_q <= 1'b0;
        else if (pwr_q == spicl_pkg::SPICL_RUN && haltReq)
            haltArm_q <= ~selInN & ~master;
        else if (!halted)
            haltArm_q <= 1'b0;
    end

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= `SPICL_CTRL_RST;
        end else if (!halted) begin
            if (modeFault) begin
                ctrl_q[`SPICL_B_PORTEN] <= 1'b0;
                ctrl_q[`SPICL_B_MASTER] <= 1'b0;
            end else if (wr && paddr == `SPICL_OFF_CTRL) begin
                ctrl_q <= pwdata[7:0];
                // no enable while fault pending outside clearing
                if (csr_q[`SPICL_B_MODE_FAULT_FLAG] && !modfSeen_q) begin
                    ctrl_q[`SPICL_B_PORTEN] <= 1'b0;
                    ctrl_q[`SPICL_B_MASTER] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // bit clock divider and shift engine
    // ------------------------------------------------------------
    logic [6:0] divCnt_q;
    logic [6:0] halfLim;
    logic [3:0] edgeCnt_q;
    logic       sckLvl_q;
    logic       sckSync_q;
    logic       sckEdge;
    logic       sampEdge;
    logic       lead;

    always_comb begin
        case ({ctrl_q[`SPICL_B_BYPASS], ctrl_q[1:0]})
            3'h4:    halfLim = 7'h01;
            3'h0:    halfLim = 7'h03;
            3'h1:    halfLim = 7'h07;
            3'h6:    halfLim = 7'h0F;
            3'h2:    halfLim = 7'h1F;
            3'h3:    halfLim = 7'h3F;
            default: halfLim = 7'h03;
        endcase
    end

    // slave edges: pin sampled directly, treated synchronous
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            sckSync_q <= 1'b0;
        else
            sckSync_q <= sckIn;
    end

    // slave counts its first edge too, so bit 7 is not lost;
    // a master frozen in halt holds its clock and data pins
    assign sckEdge = master ? (busy_q && !halted && divCnt_q == halfLim)
                            : (ctrl_q[`SPICL_B_PORTEN] && !selInN
                               && sckIn != sckSync_q);
    // even edge count on phase 0 samples, odd on phase 1
    assign lead     = ~edgeCnt_q[0];
    assign sampEdge = sckEdge & (lead ^ ctrl_q[`SPICL_B_PHASE]);
    assign doneEv   = sckEdge & (edgeCnt_q == 4'hF);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            divCnt_q  <= 7'h00;
            edgeCnt_q <= 4'h0;
            busy_q    <= 1'b0;
            sckLvl_q  <= 1'b0;
        end else if (!busy_q || !ctrl_q[`SPICL_B_PORTEN]) begin
            divCnt_q  <= 7'h00;
            edgeCnt_q <= 4'h0;
            sckLvl_q  <= ctrl_q[`SPICL_B_IDLE];
            busy_q    <= ctrl_q[`SPICL_B_PORTEN] &
                         (master ? wrDataOk
                                 : (~selInN & (sckIn != sckSync_q)));
            if (!master && ctrl_q[`SPICL_B_PORTEN] && !selInN &&
                sckIn != sckSync_q) begin
                edgeCnt_q <= 4'h1;
                busy_q    <= 1'b1;
            end
        end else begin
            divCnt_q <= (divCnt_q == halfLim) ? 7'h00 : divCnt_q + 7'h01;
            if (sckEdge) begin
                edgeCnt_q <= edgeCnt_q + 4'h1;
                sckLvl_q  <= ~sckLvl_q;
                if (edgeCnt_q == 4'hF) begin
                    busy_q <= 1'b0;
                end
            end
        end
    end

    logic sampBit;
    assign sampBit = master ? misoIn : mosiIn;

    // slave first edge is handled as a start, shift on sample edges
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shift_q <= 8'h00;
        end else if (wrDataOk) begin
            shift_q <= pwdata[7:0];
        end else if (sampEdge) begin
            shift_q <= {shift_q[6:0], sampBit};
        end else if (doneEv) begin
            // hold the received byte in place for echo if not rewritten
            shift_q <= shift_q;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            rxBuf_q <= 8'h00;
        else if (doneEv && !(csr_q[`SPICL_B_DONE]))
            rxBuf_q <= shift_q; // later bytes lost
    end

    // ------------------------------------------------------------
    // control/status register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            csrSeen_q  <= 1'b0;
            modfSeen_q <= 1'b0;
        end else begin
            if (acc && paddr == `SPICL_OFF_CSR && csr_q[`SPICL_B_DONE])
                csrSeen_q <= 1'b1;
            else if (!csr_q[`SPICL_B_DONE])
                csrSeen_q <= 1'b0;
            if (rd && paddr == `SPICL_OFF_CSR && csr_q[`SPICL_B_MODE_FAULT_FLAG])
                modfSeen_q <= 1'b1;
            else if (!csr_q[`SPICL_B_MODE_FAULT_FLAG])
                modfSeen_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            csr_q <= `SPICL_CSR_RST;
        end else begin
            if (wr && paddr == `SPICL_OFF_CSR && !halted)
                csr_q[2:0] <= pwdata[2:0];
            // clears first, sets after so sets win
            if (acc && paddr == `SPICL_OFF_DATA && csrSeen_q)
                csr_q[`SPICL_B_DONE] <= 1'b0;
            if (acc && paddr == `SPICL_OFF_DATA && csrSeen_q)
                csr_q[`SPICL_B_WRITE_COLLISION_FLAG] <= 1'b0;
            if (rd && paddr == `SPICL_OFF_CSR)
                csr_q[`SPICL_B_OVR] <= 1'b0;
            if (wr && paddr == `SPICL_OFF_CTRL && modfSeen_q)
                csr_q[`SPICL_B_MODE_FAULT_FLAG] <= 1'b0;
            if (doneEv) begin
                csr_q[`SPICL_B_DONE] <= 1'b1;
                if (csr_q[`SPICL_B_DONE])
                    csr_q[`SPICL_B_OVR] <= 1'b1;
            end
            if (wrData && busy_q)
                csr_q[`SPICL_B_WRITE_COLLISION_FLAG] <= 1'b1;
            if (modeFault && !halted)
                csr_q[`SPICL_B_MODE_FAULT_FLAG] <= 1'b1;
            csr_q[3] <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // interrupt and wake
    // ------------------------------------------------------------
    logic anyFlag;
    assign anyFlag = csr_q[`SPICL_B_DONE] | csr_q[`SPICL_B_MODE_FAULT_FLAG]
                   | csr_q[`SPICL_B_OVR];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irqReq       <= 1'b0;
            wakeFromWait <= 1'b0;
            wakeFromHalt <= 1'b0;
        end else begin
            irqReq       <= ctrl_q[`SPICL_B_IRQEN] & anyFlag & ~cpuIrqMask;
            wakeFromWait <= ctrl_q[`SPICL_B_IRQEN] & anyFlag;
            wakeFromHalt <= ctrl_q[`SPICL_B_IRQEN] & haltArm_q & halted
                            & doneEv;
        end
    end

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    logic en;
    assign en = ctrl_q[`SPICL_B_PORTEN];
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sckOut      <= 1'b0;
            sckOe       <= 1'b0;
            mosiOut     <= 1'b0;
            mosiOe      <= 1'b0;
            misoOut     <= 1'b0;
            misoOe      <= 1'b0;
            pinsAltFunc <= 1'b0;
        end else begin
            pinsAltFunc <= en;
            sckOut      <= sckLvl_q;
            sckOe       <= en & master;
            mosiOut     <= shift_q[7];
            misoOut     <= shift_q[7];
            mosiOe      <= en & master & ~csr_q[`SPICL_B_OUTDIS];
            // slave drives output only while selected
            misoOe      <= en & ~master & ~selInN
                           & ~csr_q[`SPICL_B_OUTDIS];
        end
    end
endmodule

/* bench/spicl_chk.sv */
`timescale 1ns/1ns
module spicl_chk (
    input wire logic clk,
    input wire logic resetn,
    input wire logic haltReq,
    input wire logic cpuIrqMask,
    input wire logic irqReq,
    input wire logic wakeFromWait,
    input wire logic wakeFromHalt,
    input wire logic sckOut,
    input wire logic sckOe,
    input wire logic mosiOut,
    input wire logic mosiOe,
    input wire logic misoOe,
    input wire logic pinsAltFunc
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // ------
    // pin and interrupt relations
    // ------
    AST_RESET_CLEAR:
        assert property ($rose(resetn) |-> !pinsAltFunc && !irqReq)
        else $error("enable left set after reset");
    AST_MASK:
        assert property (cpuIrqMask |=> !irqReq)
        else $error("irq raised while masked");
    AST_WAKE_WAIT:
        assert property (irqReq |-> wakeFromWait)
        else $error("irq without wait wake");
    AST_HALT_FREEZE:
        assert property ((haltReq && sckOe) [*3]
                         |-> $stable(sckOut) && $stable(mosiOut))
        else $error("master pins moved in halt");
    AST_PORT_OFF:
        assert property (!pinsAltFunc [*2] |-> !sckOe && !mosiOe && !misoOe)
        else $error("pin driven with port disabled");
    AST_SLAVE_ROLE:
        assert property (misoOe |-> !sckOe && !mosiOe)
        else $error("slave drives master pins");
    AST_MASTER_ROLE:
        assert property (mosiOe |-> sckOe)
        else $error("data out without clock out");
    AST_WAKE_PULSE:
        assert property (wakeFromHalt |=> !wakeFromHalt)
        else $error("halt wake longer than a pulse");
    AST_WAKE_IN_HALT:
        assert property (wakeFromHalt |-> $past(haltReq))
        else $error("halt wake outside halt");
endmodule

/* bench/spicl_remote.sv */
`timescale 1ns/1ns
module spicl_remote (
    input  wire logic       clk,
    input  wire logic       selN,
    input  wire logic       sckOut,
    input  wire logic       mosiOut,
    output logic            misoIn,
    output logic [7:0]      rxByte
);
    logic sckQ = 1'h0;
    logic mosiQ = 1'h0;
    initial rxByte = 8'hA5;
    // ------
    // remote slave, idle low, capture on first edge
    // ------
    always @(posedge clk) begin
        sckQ <= sckOut;
        mosiQ <= mosiOut;
        // data bit as it stood before the clock rose
        if (!selN && sckOut && !sckQ) begin
            rxByte <= {rxByte[6:0], mosiQ};
        end
    end
    // released line shows the inverse, so a stale bit never passes
    assign misoIn = selN ? ~rxByte[7] : rxByte[7];
endmodule

/* bench/spicl_tb.sv */
`timescale 1ns/1ns
`include "spicl_regs.svh"
module tb_top;
    logic        clk = 1'h0;
    logic        resetn = 1'h0;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        pready, pslverr, irqReq, wakeFromWait, wakeFromHalt;
    logic [31:0] prdata;
    logic        haltReq = 1'h0;
    logic        cpuIrqMask = 1'h0;
    logic        sckIn = 1'h0;
    logic        mosiIn = 1'h0;
    logic        selectPinN = 1'h1;
    logic        sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe;
    logic        misoIn, pinsAltFunc;
    logic [7:0]  remRx;
    logic [32:0] expQ[$];
    logic [31:0] seed = 32'h51;
    int          n_fail = 0;
    int          n_checks = 0;
    int          nHigh = 0;
    int          nWake = 0;
    localparam logic [11:0] DAT = `SPICL_OFF_DATA;
    localparam logic [11:0] CTL = `SPICL_OFF_CTRL;
    localparam logic [11:0] CSR = `SPICL_OFF_CSR;
    localparam logic [11:0] PWR = `SPICL_OFF_PWR;
    localparam logic [7:0] CODE [6] = '{8'h20, 8'h00, 8'h01, 8'h22, 8'h02,
                                        8'h03};
    localparam int DIVS [6] = '{4, 8, 16, 32, 64, 128};

    spi_control_lowpower_irq i_dut (
        .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .haltReq(haltReq),
        .cpuIrqMask(cpuIrqMask), .irqReq(irqReq),
        .wakeFromWait(wakeFromWait), .wakeFromHalt(wakeFromHalt),
        .sckIn(sckIn), .sckOut(sckOut), .sckOe(sckOe), .mosiIn(mosiIn),
        .mosiOut(mosiOut), .mosiOe(mosiOe), .misoIn(misoIn),
        .misoOut(misoOut), .misoOe(misoOe), .selectPinN(selectPinN),
        .pinsAltFunc(pinsAltFunc));
    spicl_remote i_rem (.clk(clk), .selN(!sckOe), .sckOut(sckOut),
        .mosiOut(mosiOut), .misoIn(misoIn), .rxByte(remRx));

    initial forever #50 clk = ~clk;
    // ------
    // bus tasks and result watcher
    // ------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        if (n_fail == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        expQ.push_back(e);
        apb(1'h0, a, 32'h0);
    endtask
    // remote master frame, data set half a bit before each rising edge
    task automatic ext_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            mosiIn <= b[i];
            repeat (4) @(posedge clk);
            sckIn <= 1'h1;
            repeat (4) @(posedge clk);
            sckIn <= 1'h0;
        end
        mosiIn <= ~b[0];
        repeat (4) @(posedge clk);
    endtask
    always @(posedge clk) begin
        if (sckOut) nHigh <= nHigh + 1;
        if (wakeFromHalt) nWake <= nWake + 1;
        if (psel && penable && pready && !pwrite)
            chk({pslverr, prdata}, expQ.pop_front());
    end

    initial begin
        logic [7:0] b, prev;
        int         m;
        repeat (20) @(posedge clk);
        resetn <= 1'h1;
        rd(CTL, 33'h0);
        rd(CSR, 33'h0);
        rd(12'h010, 33'h100000000);
        repeat (4) begin
            b = 8'(xs()) & 8'hAF;
            wr(CTL, {24'h0, b});
            rd(CTL, 33'(b));
        end
        wr(CSR, 32'hFF);
        rd(CSR, 33'h07);
        wr(CSR, 32'h03);
        prev = 8'hA5;
        for (int i = 0; i < 6; i++) begin
            b = 8'(xs());
            wr(CTL, 32'(8'hD0 | CODE[i]));
            wr(DAT, {24'h0, b});
            m = nHigh;
            for (int k = 0; k < 1200 && irqReq !== 1'h1; k++) @(posedge clk);
            repeat (2) @(posedge clk);
            chk(33'(nHigh - m), 33'(4 * DIVS[i]));
            chk(33'(remRx), 33'(b));
            cpuIrqMask <= 1'h1;
            repeat (2) @(posedge clk);
            chk(33'(irqReq), 33'h0);
            chk(33'(wakeFromWait), 33'h1);
            cpuIrqMask <= 1'h0;
            rd(CSR, 33'h83);
            rd(DAT, 33'(prev));
            repeat (2) @(posedge clk);
            chk(33'(irqReq), 33'h0);
            prev = b;
        end
        wr(CSR, 32'h0);
        wr(CTL, 32'hD0);
        selectPinN <= 1'h0;
        repeat (4) @(posedge clk);
        selectPinN <= 1'h1;
        chk(33'({irqReq, pinsAltFunc}), 33'h2);
        rd(CTL, 33'h80);
        rd(CSR, 33'h10);
        wr(CTL, 32'h0);
        rd(CSR, 33'h0);
        wr(CTL, 32'hC0);
        selectPinN <= 1'h0;
        haltReq <= 1'h1;
        repeat (2) @(posedge clk);
        ext_byte(8'h3C);
        haltReq <= 1'h0;
        chk(33'(nWake), 33'h1);
        rd(PWR, 33'h2);
        selectPinN <= 1'h1;
        wr(CTL, 32'h50);
        rd(PWR, 33'h0);
        wr(CTL, 32'hC0);
        selectPinN <= 1'h0;
        ext_byte(8'hC3);
        rd(CSR, 33'hA0);
        rd(DAT, 33'h3C);
        repeat (2) @(posedge clk);
        close_out();
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        close_out();
    end
endmodule

bind spi_control_lowpower_irq spicl_chk i_chk (
    .clk(clk), .resetn(resetn), .haltReq(haltReq), .cpuIrqMask(cpuIrqMask),
    .irqReq(irqReq), .wakeFromWait(wakeFromWait),
    .wakeFromHalt(wakeFromHalt), .sckOut(sckOut), .sckOe(sckOe),
    .mosiOut(mosiOut), .mosiOe(mosiOe), .misoOe(misoOe),
    .pinsAltFunc(pinsAltFunc));
